/* File: logic/sync_check_top.sv */
// System-check logic: live/dead monitors, two synchronism-check units,
// system-split detector and auto-reclose permissive.
// Assumes all inputs come from logic on ref_clk_in, so none is
// synchronised; angle and slip are measured upstream between the
// selected main quantity and the check input.
`timescale 1ns/1ps
module sync_check_top #(
	parameter int TICK_CYCLES = sync_check_pkg::TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	// Configuration
	input wire logic sys_check_en_in,
	input wire logic main_on_bus_in,
	input wire sync_check_pkg::phase_sel_t cs_input_sel_in,
	input wire logic [sync_check_pkg::V_WIDTH-1:0] live_level_in,
	input wire logic [sync_check_pkg::V_WIDTH-1:0] dead_level_in,
	input wire sync_check_pkg::cs_set_t cs1_set_in,
	input wire sync_check_pkg::cs_set_t cs2_set_in,
	input wire sync_check_pkg::vcheck_set_t vcheck_set_in,
	input wire sync_check_pkg::split_set_t split_set_in,
	// Enables from user_scheme_logic
	input wire logic cs1_ext_en_in,
	input wire logic cs2_ext_en_in,
	input wire logic split_ext_en_in,
	// Measurements
	input wire logic meas_valid_in,
	input wire logic [sync_check_pkg::PHASE_COUNT*sync_check_pkg::V_WIDTH-1:0]
		main_mag_in,
	input wire logic [sync_check_pkg::V_WIDTH-1:0] check_mag_in,
	input wire logic [sync_check_pkg::ANG_WIDTH-1:0] angle_in,
	input wire logic [sync_check_pkg::SLIP_WIDTH-1:0] slip_in,
	// Results
	output sync_check_pkg::phase_sel_t ref_sel_out,
	output logic checks_inactive_out,
	output sync_check_pkg::vstate_t vstate_out,
	output logic cs1_ok_out,
	output logic cs2_ok_out,
	output logic split_out,
	output logic ar_sys_check_ok_out
);
	import sync_check_pkg::*;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	localparam int TCW = $clog2(TICK_CYCLES + 1);

	// Tick must be a one-cycle pulse
	generate
		if (TICK_CYCLES < 2) begin : g_bad_tick
			$error("TICK_CYCLES must be at least two");
		end
	endgenerate

	logic [TCW-1:0] tick_cnt_q;
	logic tick_q;
	logic [V_WIDTH-1:0] main_sel_mag;
	logic [V_WIDTH-1:0] line_mag_q, bus_mag_q;
	logic [ANG_WIDTH-1:0] angle_q;
	logic [SLIP_WIDTH-1:0] slip_q;
	logic angle_decr_q;
	vstate_t vstate_q;
	phase_sel_t ref_sel_q;
	logic inactive_q;
	logic both_live;
	logic cs1_ok, cs2_ok;
	logic cs1_en, cs2_en;
	logic split_cond;
	logic [TMR_WIDTH-1:0] split_hold_q;
	logic split_q;
	logic ar_ok_q;

	// Millisecond tick shared by all hold timers
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == TCW'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Main quantity matching the check-input connection
	always_comb begin
		main_sel_mag = main_mag_in[V_WIDTH-1:0];
		for (int i = 0; i < PHASE_COUNT; i++) begin
			if (int'(cs_input_sel_in) == i) begin
				main_sel_mag = main_mag_in[i*V_WIDTH +: V_WIDTH];
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ref_sel_q <= SEL_A_N;
		end else begin
			ref_sel_q <= cs_input_sel_in;
		end
	end

	// Side mapping of main and check inputs
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			line_mag_q <= '0;
			bus_mag_q <= '0;
		end else if (main_on_bus_in) begin
			line_mag_q <= check_mag_in;
			bus_mag_q <= main_sel_mag;
		end else begin
			line_mag_q <= main_sel_mag;
			bus_mag_q <= check_mag_in;
		end
	end

	// Angle, slip and angle direction, updated per measurement
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			angle_q <= ANG_RESET;
			slip_q <= '0;
			angle_decr_q <= 1'b0;
		end else if (meas_valid_in) begin
			angle_q <= angle_in;
			slip_q <= slip_in;
			angle_decr_q <= angle_in < angle_q;
		end
	end

	// Live and dead monitors, all low while checks are off
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			vstate_q <= '0;
		end else begin
			vstate_q.line_live <= sys_check_en_in &&
				(line_mag_q >= live_level_in);
			vstate_q.line_dead <= sys_check_en_in &&
				(line_mag_q < dead_level_in);
			vstate_q.bus_live <= sys_check_en_in &&
				(bus_mag_q >= live_level_in);
			vstate_q.bus_dead <= sys_check_en_in &&
				(bus_mag_q < dead_level_in);
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			inactive_q <= 1'b0;
		end else begin
			inactive_q <= !sys_check_en_in;
		end
	end

	assign both_live = vstate_q.line_live && vstate_q.bus_live;
	assign cs1_en = sys_check_en_in && cs1_ext_en_in;
	assign cs2_en = sys_check_en_in && cs2_ext_en_in;

	// Two units, same logic except the second needs a decreasing angle; separate check settings, shared voltage settings
	sync_check_unit #(
		.DECR_REQ(1'b0)
	) u_cs1 (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.enable_in(cs1_en),
		.both_live_in(both_live),
		.tick_in(tick_q),
		.line_mag_in(line_mag_q),
		.bus_mag_in(bus_mag_q),
		.angle_in(angle_q),
		.angle_decr_in(angle_decr_q),
		.slip_in(slip_q),
		.set_in(cs1_set_in),
		.vset_in(vcheck_set_in),
		.ok_out(cs1_ok)
	);

	sync_check_unit #(
		.DECR_REQ(1'b1)
	) u_cs2 (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.enable_in(cs2_en),
		.both_live_in(both_live),
		.tick_in(tick_q),
		.line_mag_in(line_mag_q),
		.bus_mag_in(bus_mag_q),
		.angle_in(angle_q),
		.angle_decr_in(angle_decr_q),
		.slip_in(slip_q),
		.set_in(cs2_set_in),
		.vset_in(vcheck_set_in),
		.ok_out(cs2_ok)
	);

	// System split with minimum hold
	assign split_cond = sys_check_en_in && split_set_in.status &&
		split_ext_en_in && both_live &&
		(angle_q > split_set_in.angle) &&
		(!split_set_in.uv_block ||
		((line_mag_q > split_set_in.uv_level) &&
		(bus_mag_q > split_set_in.uv_level)));

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !sys_check_en_in) begin
			split_hold_q <= '0;
		end else if (split_cond) begin
			split_hold_q <= split_set_in.timer_ms;
		end else if (tick_q && split_hold_q != '0) begin
			split_hold_q <= split_hold_q - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			split_q <= 1'b0;
		end else begin
			split_q <= sys_check_en_in &&
				(split_cond || split_hold_q != '0);
		end
	end

	// Reclose permissive from either check unit
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ar_ok_q <= 1'b0;
		end else begin
			ar_ok_q <= cs1_ok || cs2_ok;
		end
	end

	assign ref_sel_out = ref_sel_q;
	assign checks_inactive_out = inactive_q;
	assign vstate_out = vstate_q;
	assign cs1_ok_out = cs1_ok;
	assign cs2_ok_out = cs2_ok;
	assign split_out = split_q;
	assign ar_sys_check_ok_out = ar_ok_q;

	sequence s_checks_off;
		!sys_check_en_in ##1 !sys_check_en_in;
	endsequence

	sequence s_split_end;
		split_q ##1 !split_q;
	endsequence

	line_live_a: assert property (
		sys_check_en_in && (line_mag_q >= live_level_in) |=>
		vstate_q.line_live && !(vstate_q.line_dead &&
		$past(line_mag_q) >= $past(dead_level_in)))
		else $error("line live flag wrong");
	bus_dead_a: assert property (
		vstate_q.bus_dead |-> $past(bus_mag_q) < $past(dead_level_in))
		else $error("bus dead flag without low voltage");
	checks_off_a: assert property (
		s_checks_off |=> checks_inactive_out && (vstate_q == '0) &&
		!cs1_ok && !cs2_ok && !split_q && !ar_ok_q)
		else $error("outputs active with system checks off");
	side_map_a: assert property (
		main_on_bus_in |=> line_mag_q == $past(check_mag_in))
		else $error("check input not placed opposite main input");
	live_needed_a: assert property (
		!both_live |=> !cs1_ok && !cs2_ok)
		else $error("check output without both sides live");
	ext_enable_a: assert property (
		!cs2_ext_en_in |=> !cs2_ok)
		else $error("second unit active without external enable");
	decr_flag_a: assert property (
		meas_valid_in |=> angle_decr_q == ($past(angle_in) < $past(angle_q)))
		else $error("angle direction flag wrong");
	split_set_a: assert property (
		split_cond |=> split_q)
		else $error("split flag missing with split conditions");
	split_hold_a: assert property (
		s_split_end |-> !$past(sys_check_en_in) ||
		($past(split_hold_q) == '0 && !$past(split_cond)))
		else $error("split flag dropped before hold time");
	ar_permit_a: assert property (
		cs1_ok || cs2_ok |=> ar_sys_check_ok_out)
		else $error("reclose permissive missing");
	tick_period_a: assert property (
		tick_q |=> !tick_q)
		else $error("timer tick longer than one cycle");
endmodule

/* File: logic/sync_check_pkg.sv */
// Shared widths, setting structs and timing constants for the
// synchronism-check logic.
// Assumes magnitudes, angle and slip are unsigned values prepared upstream.
package sync_check_pkg;
	localparam int V_WIDTH = 16;
	localparam int ANG_WIDTH = 16;
	localparam int SLIP_WIDTH = 16;
	localparam int TMR_WIDTH = 16;
	localparam int PHASE_COUNT = 6;

	// Timer base: one tick per millisecond of setting
	localparam longint CLK_FREQ_HZ = 125000000;
	localparam longint TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = int'((CLK_FREQ_HZ * TICK_TIME_US) / 1000000);

	localparam logic [TMR_WIDTH-1:0] TMR_MAX = {TMR_WIDTH{1'b1}};
	localparam logic [ANG_WIDTH-1:0] ANG_RESET = {ANG_WIDTH{1'b0}};

	typedef enum logic [1:0] {
		SLIP_NONE,
		SLIP_TIMER,
		SLIP_FREQ,
		SLIP_FREQ_TIMER
	} slip_mode_t;

	typedef enum logic [2:0] {
		SEL_A_N,
		SEL_B_N,
		SEL_C_N,
		SEL_A_B,
		SEL_B_C,
		SEL_C_A
	} phase_sel_t;

	typedef struct packed {
		logic uv;
		logic ov;
		logic diff;
	} vblock_t;

	typedef struct packed {
		logic status;
		logic [ANG_WIDTH-1:0] angle;
		slip_mode_t slip_mode;
		logic [SLIP_WIDTH-1:0] slip_freq;
		logic [TMR_WIDTH-1:0] slip_timer_ms;
	} cs_set_t;

	typedef struct packed {
		vblock_t block;
		logic [V_WIDTH-1:0] ov_level;
		logic [V_WIDTH-1:0] uv_level;
		logic [V_WIDTH-1:0] diff_level;
	} vcheck_set_t;

	typedef struct packed {
		logic status;
		logic [ANG_WIDTH-1:0] angle;
		logic uv_block;
		logic [V_WIDTH-1:0] uv_level;
		logic [TMR_WIDTH-1:0] timer_ms;
	} split_set_t;

	typedef struct packed {
		logic line_live;
		logic line_dead;
		logic bus_live;
		logic bus_dead;
	} vstate_t;
endpackage

/* File: logic/sync_check_unit.sv */
// One synchronism-check module: condition test plus hold timer.
// Assumes registered live flags and a one-cycle millisecond tick.
`timescale 1ns/1ps
module sync_check_unit #(
	parameter bit DECR_REQ = 1'b0
) (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic enable_in,
	input wire logic both_live_in,
	input wire logic tick_in,
	input wire logic [sync_check_pkg::V_WIDTH-1:0] line_mag_in,
	input wire logic [sync_check_pkg::V_WIDTH-1:0] bus_mag_in,
	input wire logic [sync_check_pkg::ANG_WIDTH-1:0] angle_in,
	input wire logic angle_decr_in,
	input wire logic [sync_check_pkg::SLIP_WIDTH-1:0] slip_in,
	input wire sync_check_pkg::cs_set_t set_in,
	input wire sync_check_pkg::vcheck_set_t vset_in,
	output logic ok_out
);
	import sync_check_pkg::*;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	logic [TMR_WIDTH-1:0] held_q;
	logic ok_q;
	logic armed_q;
	logic angle_ok, dir_ok, slip_ok, ov_ok, uv_ok, diff_ok;
	logic timed, cond_all;
	logic [V_WIDTH-1:0] vdiff;

	assign timed = (set_in.slip_mode == SLIP_TIMER) ||
		(set_in.slip_mode == SLIP_FREQ_TIMER);
	assign angle_ok = angle_in < set_in.angle;
	assign dir_ok = !DECR_REQ || angle_decr_in;
	assign slip_ok = !((set_in.slip_mode == SLIP_FREQ) ||
		(set_in.slip_mode == SLIP_FREQ_TIMER)) ||
		(slip_in < set_in.slip_freq);
	assign ov_ok = !vset_in.block.ov || ((line_mag_in < vset_in.ov_level) &&
		(bus_mag_in < vset_in.ov_level));
	assign uv_ok = !vset_in.block.uv || ((line_mag_in > vset_in.uv_level) &&
		(bus_mag_in > vset_in.uv_level));
	assign vdiff = (line_mag_in > bus_mag_in) ? line_mag_in - bus_mag_in :
		bus_mag_in - line_mag_in;
	assign diff_ok = !vset_in.block.diff ||
		(vdiff < vset_in.diff_level);
	assign cond_all = enable_in && set_in.status && both_live_in &&
		angle_ok && dir_ok && slip_ok && ov_ok && uv_ok && diff_ok;

	// Hold time in whole ticks; first tick after a restart only arms
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in || !cond_all) begin
			held_q <= '0;
			armed_q <= 1'b0;
		end else if (tick_in) begin
			armed_q <= 1'b1;
			if (armed_q && held_q != TMR_MAX) begin
				held_q <= held_q + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			ok_q <= 1'b0;
		end else begin
			ok_q <= cond_all &&
				(!timed || held_q >= set_in.slip_timer_ms);
		end
	end

	assign ok_out = ok_q;

	angle_block_a: assert property (
		!angle_ok |=> !ok_out)
		else $error("check output set with angle above setting");
	restart_hold_a: assert property (
		!cond_all |=> (held_q == '0) && !ok_out)
		else $error("hold timer not restarted on lost condition");
	timer_min_a: assert property (
		$rose(ok_out) && $past(timed) |->
		$past(held_q) >= $past(set_in.slip_timer_ms))
		else $error("check output before hold time elapsed");
	direction_a: assert property (
		DECR_REQ && !angle_decr_in |=> !ok_out)
		else $error("check output without decreasing angle");
endmodule

/* File: verif/scheme_logic_model.sv */
// Behavioural scheme logic that drives the enables of the check units.
// Assumes the bench posts requests just after a rising clock edge.
`timescale 1ns/1ps
module scheme_logic_model (
	input wire logic ref_clk_in,
	input wire logic [2:0] en_req_in,
	output logic cs1_en_out,
	output logic cs2_en_out,
	output logic split_en_out
);
	// Clocked scheme logic: enables follow one edge after the request
	always_ff @(posedge ref_clk_in) begin
		cs1_en_out <= en_req_in[0];
		cs2_en_out <= en_req_in[1];
		split_en_out <= en_req_in[2];
	end
endmodule

/* File: verif/synchronism_check_logic_tb.sv */
// Self-checking bench for sync_check_top against an integer model.
// Assumes scheme_logic_model and the design package are compiled first.
`timescale 1ns/1ps
module synchronism_check_logic_tb;
	import sync_check_pkg::*;
	localparam int TK = 4;
	logic ref_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic en = 1'b0;
	logic mob = 1'b0;
	logic mv = 1'b0;
	phase_sel_t sel = SEL_A_N;
	logic [15:0] live = 16'h0064;
	logic [15:0] dead = 16'h0032;
	logic [15:0] cmag = 16'h0000;
	logic [15:0] ang = 16'h0000;
	logic [15:0] slip = 16'h0000;
	logic [95:0] mmag = '0;
	cs_set_t s1 = '0;
	cs_set_t s2 = '0;
	vcheck_set_t vs = '0;
	split_set_t ss = '0;
	logic [2:0] req = 3'h0;
	logic e1, e2, e3, inact, c1, c2, spl, ar;
	phase_sel_t rsel;
	vstate_t vst;
	int err_total = 0;
	int checked = 0;
	int cyc = 0;
	int lv, bv;
	bit dec;

	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end

	scheme_logic_model far_u (.ref_clk_in(ref_clk_in), .en_req_in(req),
		.cs1_en_out(e1), .cs2_en_out(e2), .split_en_out(e3));

	sync_check_top #(.TICK_CYCLES(TK)) dut_u (.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in), .sys_check_en_in(en), .main_on_bus_in(mob),
		.cs_input_sel_in(sel), .live_level_in(live), .dead_level_in(dead),
		.cs1_set_in(s1), .cs2_set_in(s2), .vcheck_set_in(vs),
		.split_set_in(ss), .cs1_ext_en_in(e1), .cs2_ext_en_in(e2),
		.split_ext_en_in(e3), .meas_valid_in(mv), .main_mag_in(mmag),
		.check_mag_in(cmag), .angle_in(ang), .slip_in(slip),
		.ref_sel_out(rsel), .checks_inactive_out(inact), .vstate_out(vst),
		.cs1_ok_out(c1), .cs2_ok_out(c2), .split_out(spl),
		.ar_sys_check_ok_out(ar));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end

	function automatic bit cs_exp(cs_set_t s, bit two, bit ext);
		int df;
		df = (lv > bv) ? lv - bv : bv - lv;
		return en && s.status && ext && lv >= live && bv >= live
			&& ang < s.angle && (!two || dec)
			&& (!s.slip_mode[1] || slip < s.slip_freq)
			&& (!vs.block.ov || (lv < vs.ov_level && bv < vs.ov_level))
			&& (!vs.block.uv || (lv > vs.uv_level && bv > vs.uv_level))
			&& (!vs.block.diff || df < vs.diff_level);
	endfunction

	function automatic bit ss_exp();
		return en && ss.status && req[2] && lv >= live && bv >= live
			&& ang > ss.angle
			&& (!ss.uv_block || (lv > ss.uv_level && bv > ss.uv_level));
	endfunction

	function automatic cs_set_t rnd_cs();
		cs_set_t s;
		s.status = ($urandom_range(0, 3) != 0);
		s.angle = 16'($urandom_range(1, 20));
		s.slip_mode = slip_mode_t'($urandom_range(0, 3));
		s.slip_freq = 16'($urandom_range(0, 20));
		s.slip_timer_ms = 16'h0000;
		return s;
	endfunction

	// Two angle captures, so the direction flag is always defined
	task automatic apply(input int a, input bit d);
		for (int i = 0; i < 6; i++) begin
			mmag[i*16+:16] = 16'($urandom_range(0, 300));
		end
		mmag[int'(sel)*16+:16] = 16'(mob ? bv : lv);
		cmag = 16'(mob ? lv : bv);
		ang = 16'(d ? a + 1 : a - 1);
		mv = 1'b1;
		wait_cyc(1);
		ang = 16'(a);
		dec = d;
		wait_cyc(1);
		mv = 1'b0;
		wait_cyc(8);
	endtask

	task automatic compare_all();
		bit x1, x2;
		x1 = cs_exp(s1, 1'b0, req[0]);
		x2 = cs_exp(s2, 1'b1, req[1]);
		check(8'(vst), 8'({lv >= live, lv < dead, bv >= live, bv < dead}
			& {4{en}}));
		check(8'(inact), 8'(!en));
		check(8'(rsel), 8'(sel));
		check(8'(c1), 8'(x1));
		check(8'(c2), 8'(x2));
		check(8'(spl), 8'(ss_exp()));
		check(8'(ar), 8'(x1 | x2));
	endtask

	initial begin
		int seed_v;
		seed_v = $urandom(32'hB6256FF5);
		wait_cyc(3);
		nrst_in = 1'b1;
		wait_cyc(1);
		for (int i = 0; i < 60; i++) begin
			en = ($urandom_range(0, 3) != 0);
			mob = 1'($urandom_range(0, 1));
			sel = phase_sel_t'($urandom_range(0, 5));
			req = 3'($urandom_range(0, 7));
			lv = $urandom_range(45, 170);
			bv = $urandom_range(45, 170);
			slip = 16'($urandom_range(0, 20));
			s1 = rnd_cs();
			s2 = rnd_cs();
			vs.block = 3'($urandom_range(0, 7));
			vs.ov_level = 16'($urandom_range(140, 180));
			vs.uv_level = 16'($urandom_range(80, 120));
			vs.diff_level = 16'($urandom_range(0, 60));
			ss.status = ($urandom_range(0, 3) != 0);
			ss.angle = 16'($urandom_range(1, 20));
			ss.uv_block = 1'($urandom_range(0, 1));
			ss.uv_level = 16'($urandom_range(80, 120));
			ss.timer_ms = 16'h0000;
			apply($urandom_range(1, 20), 1'($urandom_range(0, 1)));
			compare_all();
		end
		// Drop the first unit so its hold count restarts from zero
		s1.status = 1'b0;
		wait_cyc(2);
		// Hold timer of the first unit: 5 ms of 4-cycle ticks
		en = 1'b1;
		req = 3'h3;
		vs.block = 3'h0;
		ss.status = 1'b0;
		s2.status = 1'b0;
		s1.status = 1'b1;
		s1.angle = 16'h001E;
		s1.slip_mode = SLIP_TIMER;
		s1.slip_timer_ms = 16'h0005;
		lv = 120;
		bv = 120;
		apply(5, 1'b1);
		check(8'(c1), 8'h00);
		wait_cyc(30);
		check(8'(c1), 8'h01);
		lv = 40;
		apply(5, 1'b1);
		check(8'(c1), 8'h00);
		lv = 120;
		apply(5, 1'b1);
		check(8'(c1), 8'h00);
		wait_cyc(30);
		check(8'(c1), 8'h01);
		// Split hold: 8 ms outlasts the drop of its condition
		s1.status = 1'b0;
		req = 3'h4;
		ss.status = 1'b1;
		ss.uv_block = 1'b0;
		ss.angle = 16'h0002;
		ss.timer_ms = 16'h0008;
		apply(5, 1'b1);
		check(8'(spl), 8'h01);
		apply(1, 1'b1);
		check(8'(spl), 8'h01);
		wait_cyc(40);
		check(8'(spl), 8'h00);
		complete_run();
	end
endmodule
